/* src/mcr_pkg.sv */
// shared constants and helpers of the motor configuration register bank
package mcr_pkg;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_MODE      = 16'h0103;
   localparam logic [15:0] ADDR_POLARITY  = 16'h0104;
   localparam logic [15:0] ADDR_MAX_SPEED = 16'h0105;
   localparam logic [15:0] ADDR_MIN_SPEED = 16'h0106;
   localparam logic [15:0] ADDR_RESTORE   = 16'h0F00;
   localparam logic [15:0] ADDR_VOLTAGE   = 16'h0200;
   localparam logic [15:0] ADDR_CURRENT   = 16'h0201;
   localparam logic [15:0] ADDR_TEMP      = 16'h0202;
   localparam logic [15:0] ADDR_SPEED     = 16'h0203;
   localparam logic [15:0] ADDR_RUN_STATE = 16'h0204;
   localparam logic [15:0] ADDR_FAULTS    = 16'h0205;
   localparam logic [15:0] ADDR_TURNS     = 16'h0206;

   // ----------------------------------------------------------------
   // reset values and field codes
   // ----------------------------------------------------------------
   localparam logic [15:0] MODE_RESET       = 16'h0000;
   localparam logic [15:0] POLARITY_RESET   = 16'h0101;
   localparam logic [15:0] MAX_SPEED_RESET  = 16'h0FA0;
   localparam logic [15:0] MIN_SPEED_RESET  = 16'h00C8;
   localparam logic [7:0]  MODE_OPEN_LOOP   = 8'h00;
   localparam logic [7:0]  MODE_CLOSED_LOOP = 8'h01;
   localparam logic [7:0]  PATH_PHYSICAL    = 8'h00;
   localparam logic [7:0]  PATH_CAN         = 8'h03;
   localparam logic [15:0] RUN_STOP         = 16'h0000;
   localparam logic [15:0] RUN_CW           = 16'h0001;
   localparam logic [15:0] RUN_CCW          = 16'h0002;
   localparam logic [15:0] RUN_BRAKE        = 16'h0003;
   localparam logic [15:0] TEMP_OFFSET      = 16'h0028;
   localparam logic [15:0] TURN_MAX         = 16'h7FFF;
   localparam logic [15:0] TURN_MIN         = 16'h8000;

   // ----------------------------------------------------------------
   // frame identifiers, low byte is the node id; reply ids carry it between ID_REPLY_HIGH and ID_REPLY_LOW
   // ----------------------------------------------------------------
   localparam logic [23:0] ID_READ       = 24'h187255;
   localparam logic [23:0] ID_WRITE      = 24'h187355;
   localparam logic [23:0] ID_LOAD_TURNS = 24'h187155;
   localparam logic [15:0] ID_REPLY_HIGH = 16'h1872;
   localparam logic [7:0]  ID_REPLY_LOW  = 8'h55;
   localparam logic [7:0]  NODE_PERMANENT = 8'h00;

   // arithmetic sum of the first six frame bytes, byte 1 in the top lane
   function automatic logic [15:0] frame_sum(input logic [47:0] bytes);
      logic [15:0] acc;
      acc = 16'h0000;
      for (int i = 0; i < 6; i++)
      begin
         acc = acc + {8'h00, bytes[8*i +: 8]};
      end
      return acc;
   endfunction

endpackage

/* src/mcr_turn_counter.sv */
// saturating signed electrical-revolution counter with load
`timescale 1ns/10ps
module mcr_turn_counter
   import mcr_pkg::*;
#(
   parameter int WIDTH = 16
)(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             sys_rst,
   // count events
   input  wire logic             step_pulse,
   input  wire logic             step_fwd,
   // load from host
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_value,
   // value
   output logic      [WIDTH-1:0] count
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
   } mcr_turn_state_t;

   mcr_turn_state_t s_q;
   mcr_turn_state_t s_d;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      if (load)
      begin
         s_d.count = load_value;
      end
      else if (step_pulse)
      begin
         // hold at either end instead of wrapping
         if (step_fwd && s_q.count != WIDTH'(TURN_MAX))
         begin
            s_d.count = s_q.count + WIDTH'(1);
         end
         else if (!step_fwd && s_q.count != WIDTH'(TURN_MIN))
         begin
            s_d.count = s_q.count - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign count = s_q.count;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_turn_hold_max;
      @(posedge clock) disable iff (sys_rst)
      (!load && step_pulse && step_fwd && count == WIDTH'(TURN_MAX)) |=> count == WIDTH'(TURN_MAX);
   endproperty
   a_turn_hold_max: assert property (p_turn_hold_max) else $error("counter wrapped at top");

   property p_turn_step;
      @(posedge clock) disable iff (sys_rst)
      (!load && step_pulse && !step_fwd && count != WIDTH'(TURN_MIN))
      |=> count == WIDTH'($past(count) - WIDTH'(1));
   endproperty
   a_turn_step: assert property (p_turn_step) else $error("reverse step not counted");

   property p_turn_load;
      @(posedge clock) disable iff (sys_rst)
      load |=> count == $past(load_value);
   endproperty
   a_turn_load: assert property (p_turn_load) else $error("load value not taken");

endmodule

/* src/mcr_register_bank.sv */
// special-function register bank of a motor drive reached over CAN frames
//
// Functional notes
// - work-mode high byte 0x00 open loop, 0x01 closed loop, others invalid.
// - work-mode low byte 0x03 takes speed and direction from CAN commands.
// - low byte 0x00 takes speed from analog input, direction from pins.
// - work-mode register at 0x0103, resets to 0x0000.
// - direction register at 0x0104, resets to 0x0101.
// - direction high byte zero inverts commanded rotation; nonzero keeps it.
// - direction low byte zero inverts reported speed sign; nonzero keeps it.
// - maximum speed limit resets to 0x0FA0 rpm.
// - minimum speed limit resets to 0x00C8 rpm.
// - any write to restore register returns all configuration to defaults.
// - reply repeats address high first, then data high then low.
// - run state reads 0 stop, 1 clockwise, 2 counterclockwise, 3 braking.
// - position counts electrical revolutions signed with rotation direction.
// - position is signed 16-bit and holds at either limit.
// - position is loadable from a frame with id 0x187155 plus node.
// - bytes 7-8 carry 16-bit sum of bytes 1-6; mismatches are discarded.
// - each fault bit reads 1 while its fault is present.
// - temperature reads degrees Celsius plus 40.
// - frames accepted only for configured node id or permanent id 0x00.
`timescale 1ns/10ps
module mcr_register_bank
   import mcr_pkg::*;
#(
   parameter int SPEED_W = 14
)(
   // clock and reset
   input  wire logic               clock,
   input  wire logic               sys_rst,
   // received frames
   input  wire logic               rx_valid,
   input  wire logic [31:0]        rx_id,
   input  wire logic [63:0]        rx_data,
   input  wire logic [7:0]         node_id,
   // reply frames
   output logic                    tx_valid,
   output logic      [31:0]        tx_id,
   output logic      [63:0]        tx_data,
   // measurements from the drive
   input  wire logic [15:0]        bus_voltage,
   input  wire logic [15:0]        bus_current,
   input  wire logic [15:0]        temp_celsius,
   input  wire logic [15:0]        motor_speed,
   input  wire logic               motor_running,
   input  wire logic               motor_braking,
   input  wire logic               motor_turn_fwd,
   input  wire logic [7:0]         fault_flags,
   input  wire logic               turn_pulse,
   input  wire logic               turn_fwd,
   // command sources
   input  wire logic               can_cmd_run,
   input  wire logic               can_cmd_fwd,
   input  wire logic [SPEED_W-1:0] can_cmd_speed,
   input  wire logic [SPEED_W-1:0] analog_speed_input,
   input  wire logic               clockwise_run,
   input  wire logic               counterclockwise_run,
   // configuration and command outputs
   output logic                    closed_loop_mode,
   output logic                    can_path_sel,
   output logic                    cmd_run,
   output logic                    cmd_fwd,
   output logic      [SPEED_W-1:0] cmd_speed,
   output logic      [15:0]        max_speed_limit,
   output logic      [15:0]        min_speed_limit,
   output logic      [15:0]        turn_count
);

   typedef struct packed {
      logic [15:0]        mode;
      logic [15:0]        polarity;
      logic [15:0]        max_limit;
      logic [15:0]        min_limit;
      logic               closed_loop;
      logic               can_path;
      logic               run;
      logic               fwd;
      logic [SPEED_W-1:0] speed;
      logic               tx_valid;
      logic [31:0]        tx_id;
      logic [63:0]        tx_data;
   } mcr_bank_t;

   localparam mcr_bank_t BANK_RESET = '{
      mode:      MODE_RESET,
      polarity:  POLARITY_RESET,
      max_limit: MAX_SPEED_RESET,
      min_limit: MIN_SPEED_RESET,
      default:   '0
   };

   mcr_bank_t   s_q;
   mcr_bank_t   s_d;

   // ----------------------------------------------------------------
   // frame decode
   // ----------------------------------------------------------------
   logic        node_ok;
   logic        sum_ok;
   logic        frame_ok;
   logic        acc_read;
   logic        acc_write;
   logic        acc_load;
   logic [15:0] rx_addr;
   logic [15:0] rx_value;
   logic        mode_code_ok;
   logic        turn_load;
   logic [15:0] rd_value;
   logic        rd_hit;
   logic        fb_fwd;
   logic [15:0] fb_speed;
   logic [47:0] reply_head;

   assign node_ok  = (rx_id[7:0] == node_id) || (rx_id[7:0] == NODE_PERMANENT);
   assign sum_ok   = frame_sum(rx_data[63:16]) == rx_data[15:0];
   assign frame_ok = rx_valid && node_ok && sum_ok;
   assign acc_read  = frame_ok && (rx_id[31:8] == ID_READ);
   assign acc_write = frame_ok && (rx_id[31:8] == ID_WRITE);
   assign acc_load  = frame_ok && (rx_id[31:8] == ID_LOAD_TURNS);
   assign rx_addr  = rx_data[63:48];
   assign rx_value = rx_data[47:32];
   assign mode_code_ok = (rx_value[15:8] == MODE_OPEN_LOOP) ||
                         (rx_value[15:8] == MODE_CLOSED_LOOP);
   assign turn_load = acc_load || (acc_write && rx_addr == ADDR_TURNS);

   // feedback polarity applied to measured direction and speed
   assign fb_fwd   = (s_q.polarity[7:0] != 8'h00) ? motor_turn_fwd : !motor_turn_fwd;
   assign fb_speed = (s_q.polarity[7:0] != 8'h00) ? motor_speed
                                                  : 16'(16'h0000 - motor_speed);

   // ----------------------------------------------------------------
   // read mux; live measurements are sampled in the cycle of the request
   // ----------------------------------------------------------------
   always_comb
   begin
      rd_hit   = 1'b1;
      rd_value = 16'h0000;
      case (rx_addr)
         ADDR_MODE:      rd_value = s_q.mode;
         ADDR_POLARITY:  rd_value = s_q.polarity;
         ADDR_MAX_SPEED: rd_value = s_q.max_limit;
         ADDR_MIN_SPEED: rd_value = s_q.min_limit;
         ADDR_VOLTAGE:   rd_value = bus_voltage;
         ADDR_CURRENT:   rd_value = bus_current;
         ADDR_TEMP:      rd_value = 16'(temp_celsius + TEMP_OFFSET);
         ADDR_SPEED:     rd_value = fb_speed;
         ADDR_RUN_STATE:
         begin
            if (motor_braking)
               rd_value = RUN_BRAKE;
            else if (motor_running)
               rd_value = fb_fwd ? RUN_CW : RUN_CCW;
            else
               rd_value = RUN_STOP;
         end
         ADDR_FAULTS:    rd_value = {8'h00, fault_flags};
         ADDR_TURNS:     rd_value = turn_count;
         default:        rd_hit   = 1'b0;
      endcase
   end

   assign reply_head = {rx_addr, rd_value, 16'h0000};

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.tx_valid = 1'b0;
      // measurement addresses are not decoded for writes here; a write to ADDR_TURNS still loads the position counter
      if (acc_write)
      begin
         case (rx_addr)
            ADDR_MODE:
            begin
               if (mode_code_ok)
                  s_d.mode = rx_value;
            end
            ADDR_POLARITY:  s_d.polarity  = rx_value;
            ADDR_MAX_SPEED: s_d.max_limit = rx_value;
            ADDR_MIN_SPEED: s_d.min_limit = rx_value;
            ADDR_RESTORE:
            begin
               s_d.mode      = MODE_RESET;
               s_d.polarity  = POLARITY_RESET;
               s_d.max_limit = MAX_SPEED_RESET;
               s_d.min_limit = MIN_SPEED_RESET;
            end
            default:
            begin
               s_d.mode = s_q.mode;
            end
         endcase
      end
      if (acc_read && rd_hit)
      begin
         s_d.tx_valid = 1'b1;
         s_d.tx_id    = {ID_REPLY_HIGH, node_id, ID_REPLY_LOW};
         s_d.tx_data  = {reply_head, frame_sum(reply_head)};
      end
      s_d.closed_loop = s_d.mode[15:8] == MODE_CLOSED_LOOP;
      s_d.can_path    = s_d.mode[7:0] == PATH_CAN;
      // command selection follows the current path; unknown paths stop the motor
      if (s_q.mode[7:0] == PATH_CAN)
      begin
         s_d.run   = can_cmd_run;
         s_d.fwd   = (s_q.polarity[15:8] != 8'h00) ? can_cmd_fwd : !can_cmd_fwd;
         s_d.speed = can_cmd_speed;
      end
      else if (s_q.mode[7:0] == PATH_PHYSICAL)
      begin
         // both direction pins at once is treated as stop
         s_d.run   = clockwise_run ^ counterclockwise_run;
         s_d.fwd   = (s_q.polarity[15:8] != 8'h00) ? clockwise_run
                                                   : !clockwise_run;
         s_d.speed = analog_speed_input;
      end
      else
      begin
         s_d.run   = 1'b0;
         s_d.fwd   = 1'b1;
         s_d.speed = '0;
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         s_q <= BANK_RESET;
      else
         s_q <= s_d;
   end

   // ----------------------------------------------------------------
   // position counter
   // ----------------------------------------------------------------
   mcr_turn_counter #(
      .WIDTH      (16)
   ) u_turns (
      .clock      (clock),
      .sys_rst    (sys_rst),
      .step_pulse (turn_pulse),
      .step_fwd   (turn_fwd),
      .load       (turn_load),
      .load_value (rx_value),
      .count      (turn_count)
   );

   assign tx_valid         = s_q.tx_valid;
   assign tx_id            = s_q.tx_id;
   assign tx_data          = s_q.tx_data;
   assign closed_loop_mode = s_q.closed_loop;
   assign can_path_sel     = s_q.can_path;
   assign cmd_run          = s_q.run;
   assign cmd_fwd          = s_q.fwd;
   assign cmd_speed        = s_q.speed;
   assign max_speed_limit  = s_q.max_limit;
   assign min_speed_limit  = s_q.min_limit;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_mode_valid;
      @(posedge clock) disable iff (sys_rst)
      s_q.mode[15:8] == MODE_OPEN_LOOP || s_q.mode[15:8] == MODE_CLOSED_LOOP;
   endproperty
   a_mode_valid: assert property (p_mode_valid) else $error("invalid regulation stored");

   property p_mode_keep;
      @(posedge clock) disable iff (sys_rst)
      (acc_write && rx_addr == ADDR_MODE && !mode_code_ok) |=> $stable(s_q.mode);
   endproperty
   a_mode_keep: assert property (p_mode_keep) else $error("invalid mode write taken");

   property p_mode_write;
      @(posedge clock) disable iff (sys_rst)
      (acc_write && rx_addr == ADDR_MODE && mode_code_ok)
      |=> s_q.mode == $past(rx_value) ##1 can_path_sel == (s_q.mode[7:0] == PATH_CAN);
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode write lost");

   property p_restore;
      @(posedge clock) disable iff (sys_rst)
      (acc_write && rx_addr == ADDR_RESTORE) |=> s_q.polarity == POLARITY_RESET
         && max_speed_limit == MAX_SPEED_RESET && min_speed_limit == MIN_SPEED_RESET
         && s_q.mode == MODE_RESET;
   endproperty
   a_restore: assert property (p_restore) else $error("restore incomplete");

   property p_can_path;
      @(posedge clock) disable iff (sys_rst)
      (s_q.mode[7:0] == PATH_CAN && s_q.polarity[15:8] != 8'h00)
      |=> cmd_speed == $past(can_cmd_speed) && cmd_fwd == $past(can_cmd_fwd);
   endproperty
   a_can_path: assert property (p_can_path) else $error("CAN command not followed");

   property p_pin_path;
      @(posedge clock) disable iff (sys_rst)
      (s_q.mode[7:0] == PATH_PHYSICAL && clockwise_run && !counterclockwise_run
       && s_q.polarity[15:8] == 8'h00) |=> cmd_run && !cmd_fwd
       && cmd_speed == $past(analog_speed_input);
   endproperty
   a_pin_path: assert property (p_pin_path) else $error("pin direction not inverted");

   property p_reply;
      @(posedge clock) disable iff (sys_rst)
      (acc_read && rx_addr == ADDR_POLARITY && !acc_write)
      |=> tx_valid && tx_data[63:32] == {ADDR_POLARITY, s_q.polarity}
          && tx_data[15:0] == frame_sum(tx_data[63:16]);
   endproperty
   a_reply: assert property (p_reply) else $error("reply layout wrong");

   property p_bad_sum;
      @(posedge clock) disable iff (sys_rst)
      (rx_valid && frame_sum(rx_data[63:16]) != rx_data[15:0]) |=> !tx_valid;
   endproperty
   a_bad_sum: assert property (p_bad_sum) else $error("bad checksum answered");

   property p_foreign_node;
      @(posedge clock) disable iff (sys_rst)
      (rx_valid && rx_id[7:0] != node_id && rx_id[7:0] != NODE_PERMANENT) |=> !tx_valid;
   endproperty
   a_foreign_node: assert property (p_foreign_node) else $error("foreign frame answered");

   property p_run_brake;
      @(posedge clock) disable iff (sys_rst)
      (acc_read && rx_addr == ADDR_RUN_STATE && motor_braking) |=> tx_data[47:32] == RUN_BRAKE;
   endproperty
   a_run_brake: assert property (p_run_brake) else $error("brake state misreported");

   property p_temp;
      @(posedge clock) disable iff (sys_rst)
      (acc_read && rx_addr == ADDR_TEMP)
      |=> 16'(tx_data[47:32] - TEMP_OFFSET) == $past(temp_celsius);
   endproperty
   a_temp: assert property (p_temp) else $error("temperature offset wrong");

   property p_faults;
      @(posedge clock) disable iff (sys_rst)
      (acc_read && rx_addr == ADDR_FAULTS) |=> tx_data[39:32] == $past(fault_flags);
   endproperty
   a_faults: assert property (p_faults) else $error("fault bits misreported");

   property p_speed_sign;
      @(posedge clock) disable iff (sys_rst)
      (acc_read && rx_addr == ADDR_SPEED && s_q.polarity[7:0] == 8'h00)
      |=> 16'(tx_data[47:32] + $past(motor_speed)) == 16'h0000;
   endproperty
   a_speed_sign: assert property (p_speed_sign) else $error("speed sign not inverted");

   property p_ro_write;
      @(posedge clock) disable iff (sys_rst)
      (acc_write && rx_addr == ADDR_VOLTAGE) |=> $stable(s_q.mode) && $stable(s_q.polarity)
         && $stable(max_speed_limit) && $stable(min_speed_limit);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write had effect");

   property p_no_reply_undef;
      @(posedge clock) disable iff (sys_rst)
      (rx_valid && rx_id[31:8] == ID_READ && rx_addr == ADDR_RESTORE) |=> !tx_valid;
   endproperty
   a_no_reply_undef: assert property (p_no_reply_undef) else $error("undefined read answered");

endmodule

/* tb/mcr_host_model.sv */
// host-side model that frames register requests for the register bank
`timescale 1ns/10ps
module mcr_host_model;
   // ----------------------------------------------------------------
   // frame lines towards the bank
   // ----------------------------------------------------------------
   logic        rx_valid = 1'b0;
   logic [31:0] rx_id    = 32'h0000_0000;
   logic [63:0] rx_data  = 64'h0000_0000_0000_0000;

   // one frame per call, launched on a falling edge; bad spoils the sum on purpose
   task automatic send(input logic [23:0] pre, input logic [7:0] nd, input logic [15:0] adr,
                       input logic [15:0] dat, input logic bad, ref logic clk);
      logic [15:0] sum;
      sum = adr[15:8] + adr[7:0] + dat[15:8] + dat[7:0] + {15'h0000, bad};
      @(negedge clk);
      rx_valid = 1'b1;
      rx_id    = {pre, nd};
      rx_data  = {adr, dat, 16'h0000, sum};
      @(negedge clk);
      // released lines must not keep showing the last frame
      rx_valid = 1'b0;
      rx_data  = ~rx_data;
      rx_id    = ~rx_id;
   endtask
endmodule

/* tb/mcr_register_bank_test.sv */
// self-checking bench of the motor configuration register bank
`timescale 1ns/10ps
module mcr_register_bank_test;
   import mcr_pkg::*;
   logic        clock = 1'b0, sys_rst = 1'b1, tx_valid, closed_loop_mode, can_path_sel;
   logic        cmd_run, cmd_fwd, rx_valid, motor_running = 1'b1, motor_braking = 1'b0;
   logic        motor_turn_fwd = 1'b1, turn_pulse = 1'b0, turn_fwd = 1'b1, can_cmd_run = 1'b1;
   logic        can_cmd_fwd = 1'b0, clockwise_run = 1'b1, counterclockwise_run = 1'b0;
   logic [7:0]  node_id = 8'h2A, fault_flags = 8'hA5;
   logic [13:0] can_cmd_speed = 14'h0123, analog_speed_input = 14'h0456, cmd_speed;
   logic [15:0] bus_voltage = 16'h0030, bus_current = 16'h0007, temp_celsius = 16'h0019;
   logic [15:0] motor_speed = 16'h0100, max_speed_limit, min_speed_limit, turn_count;
   logic [31:0] rx_id, tx_id;
   logic [63:0] rx_data, tx_data;
   logic [15:0] cfg_a [4] = '{ADDR_MODE, ADDR_POLARITY, ADDR_MAX_SPEED, ADDR_MIN_SPEED};
   logic [15:0] cfg_d [4] = '{16'h0000, 16'h0101, 16'h0FA0, 16'h00C8};
   int          num_errors = 0, n_checks = 0;

   always #2.5 clock = ~clock;
   mcr_host_model mcr_host_model_inst ();
   assign rx_valid = mcr_host_model_inst.rx_valid;
   assign rx_id    = mcr_host_model_inst.rx_id;
   assign rx_data  = mcr_host_model_inst.rx_data;
   mcr_register_bank mcr_register_bank_inst (.*);

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // reply is sampled half a cycle after the taking edge, while tx_valid still stands
   task automatic rd(input logic [15:0] adr, input logic [15:0] exp, input logic rep,
                     input logic [7:0] nd = node_id, input logic bad = 1'b0);
      mcr_host_model_inst.send(ID_READ, nd, adr, 16'h0000, bad, clock);
      check("reply", {15'h0000, rep}, {15'h0000, tx_valid});
      if (rep)
      begin
         check("addr", adr, tx_data[63:48]);
         check("data", exp, tx_data[47:32]);
         check("id", {ID_REPLY_HIGH[7:0], node_id}, tx_id[23:8]);
         check("resv", 16'h0000, tx_data[31:16]);
         check("sum", {8'h00, adr[15:8]} + adr[7:0] + exp[15:8] + exp[7:0], tx_data[15:0]);
      end
   endtask

   task automatic wr(input logic [15:0] adr, input logic [15:0] dat, input logic [23:0] p = ID_WRITE);
      mcr_host_model_inst.send(p, NODE_PERMANENT, adr, dat, 1'b0, clock);
   endtask

   task automatic defaults();
      for (int i = 0; i < 4; i++)
         rd(cfg_a[i], cfg_d[i], 1'b1);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      repeat (16) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'b0;
      defaults();
      $display("test defaults done");
      wr(ADDR_MODE, 16'h0103);
      rd(ADDR_MODE, 16'h0103, 1'b1);
      check("closed", 16'h0001, {15'h0000, closed_loop_mode});
      check("canpath", 16'h0001, {15'h0000, can_path_sel});
      check("speed", {2'b00, can_cmd_speed}, {2'b00, cmd_speed});
      wr(ADDR_MODE, 16'h0203);
      rd(ADDR_MODE, 16'h0103, 1'b1);
      wr(ADDR_MODE, 16'h0000);
      rd(ADDR_MODE, 16'h0000, 1'b1);
      check("pin run", 16'h0003, {14'h0000, cmd_run, cmd_fwd});
      wr(ADDR_POLARITY, 16'h0001);
      rd(ADDR_POLARITY, 16'h0001, 1'b1);
      check("inv fwd", 16'h0002, {14'h0000, cmd_run, cmd_fwd});
      wr(ADDR_MAX_SPEED, 16'h0BB8);
      wr(ADDR_MIN_SPEED, 16'h0064);
      wr(ADDR_MODE, 16'h0103);
      check("max", 16'h0BB8, max_speed_limit);
      check("min", 16'h0064, min_speed_limit);
      wr(ADDR_RESTORE, 16'h5A5A);
      defaults();
      check("max", 16'h0FA0, max_speed_limit);
      check("min", 16'h00C8, min_speed_limit);
      check("canpath", 16'h0000, {15'h0000, can_path_sel});
      rd(ADDR_RESTORE, 16'h0000, 1'b0);
      $display("test configuration done");
      rd(ADDR_MODE, 16'h0000, 1'b0, 8'h77);
      rd(ADDR_MODE, 16'h0000, 1'b0, node_id, 1'b1);
      wr(ADDR_TEMP, 16'h1234);
      rd(ADDR_TEMP, 16'h0041, 1'b1);
      rd(ADDR_FAULTS, 16'h00A5, 1'b1);
      rd(ADDR_RUN_STATE, RUN_CW, 1'b1);
      rd(ADDR_VOLTAGE, 16'h0030, 1'b1);
      rd(ADDR_CURRENT, 16'h0007, 1'b1);
      wr(ADDR_VOLTAGE, 16'h1234);
      rd(ADDR_SPEED, 16'h0100, 1'b1);
      wr(ADDR_POLARITY, 16'h0100);
      rd(ADDR_SPEED, 16'hFF00, 1'b1);
      rd(ADDR_RUN_STATE, RUN_CCW, 1'b1);
      @(negedge clock);
      motor_braking = 1'b1;
      rd(ADDR_RUN_STATE, RUN_BRAKE, 1'b1);
      motor_braking = 1'b0;
      $display("test measurements done");
      for (int s = 0; s < 2; s++)
      begin
         wr(16'h0000, s ? 16'h8001 : 16'h7FFE, ID_LOAD_TURNS);
         @(negedge clock);
         turn_fwd   = !s;
         turn_pulse = 1'b1;
         repeat (3) @(negedge clock);
         turn_pulse = 1'b0;
         check("turns", s ? 16'h8000 : 16'h7FFF, turn_count);
      end
      $display("test turn counter done");
      give_verdict();
   end
endmodule
